/* File: hw/bmh_pkg.sv */
// shared constants and types of the battery manager host command port
package bmh_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int INT_PULSE_NS    = 8000;
  localparam int INT_PULSE_CYC   = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int CMD_CODE_LSB    = 5;
  localparam int ADDR_W          = 5;
  localparam logic [2:0] CMD_NOP       = 3'h0;
  localparam logic [2:0] CMD_SYS_OFF   = 3'h1;
  localparam logic [2:0] CMD_RAM_RD    = 3'h2;
  localparam logic [2:0] CMD_REG_RD    = 3'h3;
  localparam logic [2:0] CMD_RAM_WR    = 3'h4;
  localparam logic [2:0] CMD_REG_WR    = 3'h5;
  localparam logic [2:0] CMD_CHG_START = 3'h6;
  localparam logic [2:0] CMD_CHG_ABORT = 3'h7;

  // ----------------------------------------------------------------
  // data groups
  // ----------------------------------------------------------------
  localparam int RAM_BYTES       = 32;
  localparam int REG_BYTES       = 17;
  localparam logic [4:0] REG_ADDR_MAX = 5'h10;

  localparam logic [4:0] IDX_CHG_PERIOD   = 5'h00;
  localparam logic [4:0] IDX_SETUP1       = 5'h01;
  localparam logic [4:0] IDX_SETUP2       = 5'h02;
  localparam logic [4:0] IDX_DIS_PERIOD   = 5'h03;
  localparam logic [4:0] IDX_END_CELL_V   = 5'h04;
  localparam logic [4:0] IDX_GAUGE_HI     = 5'h05;
  localparam logic [4:0] IDX_GAUGE_LO     = 5'h06;
  localparam logic [4:0] IDX_THRESH_HI    = 5'h07;
  localparam logic [4:0] IDX_THRESH_LO    = 5'h08;
  localparam logic [4:0] IDX_LASTCAP_HI   = 5'h09;
  localparam logic [4:0] IDX_LASTCAP_LO   = 5'h0A;
  localparam logic [4:0] IDX_MAX_TIME     = 5'h0B;
  localparam logic [4:0] IDX_MAX_CELL_V   = 5'h0C;
  localparam logic [4:0] IDX_ANN_MASK     = 5'h0D;
  localparam logic [4:0] IDX_ANN_CTRL     = 5'h0E;
  localparam logic [4:0] IDX_STATUS       = 5'h0F;
  localparam logic [4:0] IDX_TRICKLE      = 5'h10;

  // registers the host may write (one bit per index)
  localparam logic [16:0] REG_WRITABLE    = 17'h1_799F;
  localparam logic [7:0]  SETUP1_RESET    = 8'h0A;
  localparam logic [7:0]  REG_RESET       = 8'h00;

  // status byte bit positions
  localparam int ST_PWR_STATE    = 7;
  localparam int ST_SEC_FAULT    = 6;
  localparam int ST_GAUGE_NV     = 5;
  localparam int ST_DC_VALID     = 4;
  localparam int ST_BACKUP_LOW   = 3;
  localparam int ST_END_DIS      = 2;
  localparam int ST_CHARGING     = 1;
  localparam int ST_INT_FLAG     = 0;

  localparam int ANN_OUTS        = 7;
  localparam int ANN_STATUS_OUTS = 6;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       register_select;
    logic [7:0] data;
  } bmh_host_req_s;

  typedef struct packed {
    logic        sec_fault;
    logic        gauge_not_valid;
    logic        dc_valid;
    logic        backup_low;
    logic        end_discharge;
    logic        charging;
    logic [15:0] gauge;
    logic [15:0] last_capacity;
  } bmh_monitor_s;

  typedef struct packed {
    logic start;
    logic abort;
    logic stop;
    logic auto_start_allowed;
  } bmh_charge_ctl_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RAM_RD = 3'b001,
    ST_REG_RD = 3'b011,
    ST_REG_WR = 3'b010,
    ST_RAM_WR = 3'b110
  } bmh_access_e;

endpackage

/* File: hw/bmh_byte_ram.sv */
// small synchronous byte memory with registered read data
`timescale 1ns/100ps
module bmh_byte_ram
  import bmh_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = RAM_BYTES,
  parameter int AW    = ADDR_W
) (
  input  wire logic             ref_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_en,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // contents are kept across reset, as under backup power
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // bmh_byte_ram

/* File: hw/bmh_pulse_timer.sv */
// fixed-length pulse generator for the interrupt output
`timescale 1ns/100ps
module bmh_pulse_timer
  import bmh_pkg::*;
#(
  parameter int LENGTH = INT_PULSE_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic trigger,
  output logic      active
);

  localparam int CW = $clog2(LENGTH + 1);
  localparam logic [CW-1:0] LOAD = CW'(LENGTH);

  logic [CW-1:0] remaining;

  // a retrigger restarts the full length
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      remaining <= '0;
    end else if (trigger) begin
      remaining <= LOAD;
    end else if (remaining != '0) begin
      remaining <= remaining - CW'(1);
    end
  end

  assign active = (remaining != '0);

endmodule // bmh_pulse_timer

/* File: hw/bmh_command_port.sv */
// host command port: command decode, data groups, power switch and interrupt
//
// Behaviour
// [RULE1] mask zero: output follows host control bit
// [RULE2] button press while off: state on, stop, drive
// [RULE3] system off: release drive, clear state bit
// [RULE4] button press: 8 us interrupt pulse, flag
// [RULE5] select low write is a command byte
// [RULE6] command acts or arms next data byte
// [RULE7] 32 bytes of retained storage RAM
// [RULE8] 17 control/status bytes, separate group
// [RULE9] host puts address in bits 0-4
// [RULE10] code 000 nop,001 off,110 start,111 abort
// [RULE11] 100/010 write/read storage RAM byte
// [RULE12] 101/011 write/read control/status byte
// [RULE13] start charge now or when DC valid
// [RULE14] power state on: only command starts charge
// [RULE15] abort: stop charge, zero gauge, monitor
// [RULE16] mask one: output follows status bit (outputs 0-5 only; output 6 stays off)
// [RULE17] register address above 16 is ignored
`timescale 1ns/100ps
module bmh_command_port
  import bmh_pkg::*;
#(
  parameter int INT_PULSE_LEN = INT_PULSE_CYC
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire bmh_host_req_s        host_req,
  output logic [7:0]                host_rdata,
  output logic                      host_rdata_oe,
  input  wire logic                 power_button_input,
  output logic                      supply_switch_drive_out,
  output logic                      supply_switch_drive_oe,
  output logic                      interrupt_out,
  output logic                      interrupt_oe,
  output logic [ANN_OUTS-1:0]       annunciator_power_outputs_out,
  output logic [ANN_OUTS-1:0]       annunciator_power_outputs_oe,
  input  wire bmh_monitor_s         monitor,
  output bmh_charge_ctl_s           charge_ctl
);

  // ----------------------------------------------------------------
  // command and data strobes
  // ----------------------------------------------------------------
  logic [2:0]         cmd_code;
  logic [4:0]         cmd_addr;
  logic               cmd_wr;
  logic               data_wr;
  logic               data_rd;
  logic               reg_addr_ok;

  assign cmd_code    = host_req.data[7:CMD_CODE_LSB];
  assign cmd_addr    = host_req.data[ADDR_W-1:0];
  assign cmd_wr      = host_req.wr && !host_req.register_select;  // [RULE5]
  assign data_wr     = host_req.wr && host_req.register_select;   // [RULE6]
  assign data_rd     = host_req.rd && host_req.register_select;   // [RULE6]
  assign reg_addr_ok = (cmd_addr <= REG_ADDR_MAX);                // [RULE17]

  // ----------------------------------------------------------------
  // pending data-byte access
  // ----------------------------------------------------------------
  bmh_access_e access;
  bmh_access_e next_access;
  logic [4:0]  access_addr;

  always_comb begin
    next_access = access;
    if (cmd_wr) begin
      case (cmd_code)                                             // [RULE10]
        CMD_RAM_RD: next_access = ST_RAM_RD;                      // [RULE11]
        CMD_RAM_WR: next_access = ST_RAM_WR;                      // [RULE11]
        CMD_REG_RD: next_access = reg_addr_ok ? ST_REG_RD : ST_IDLE; // [RULE12] [RULE17]
        CMD_REG_WR: next_access = reg_addr_ok ? ST_REG_WR : ST_IDLE; // [RULE12] [RULE17]
        default:    next_access = ST_IDLE;
      endcase
    end else if (data_wr || data_rd) begin
      next_access = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      access <= ST_IDLE;
    end else begin
      access <= next_access;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      access_addr <= '0;
    end else if (cmd_wr) begin
      access_addr <= cmd_addr;                                    // [RULE9]
    end
  end

  // ----------------------------------------------------------------
  // storage RAM
  // ----------------------------------------------------------------
  logic       ram_wr_en;
  logic       ram_rd_en;
  logic [7:0] ram_rd_data;

  assign ram_wr_en = data_wr && (access == ST_RAM_WR);           // [RULE11]
  assign ram_rd_en = cmd_wr && (cmd_code == CMD_RAM_RD);         // [RULE11]

  bmh_byte_ram #(
    .WIDTH (8),
    .DEPTH (RAM_BYTES),
    .AW    (ADDR_W)
  ) u_storage (                                                   // [RULE7]
    .ref_clk (ref_clk),
    .wr_en   (ram_wr_en),
    .wr_addr (access_addr),
    .wr_data (host_req.data),
    .rd_en   (ram_rd_en),
    .rd_addr (cmd_addr),
    .rd_data (ram_rd_data)
  );

  // ----------------------------------------------------------------
  // control and status registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_reg [REG_BYTES];
  logic [7:0] status_byte;
  logic       power_state;
  logic       int_flag;
  logic       reg_wr_en;

  assign reg_wr_en = data_wr && (access == ST_REG_WR);           // [RULE12]

  for (genvar i = 0; i < REG_BYTES; i++) begin : g_ctrl
    localparam logic [7:0] RESET_VAL = (i == int'(IDX_SETUP1)) ? SETUP1_RESET : REG_RESET;
    if (REG_WRITABLE[i]) begin : g_rw
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          ctrl_reg[i] <= RESET_VAL;
        end else if (reg_wr_en && (access_addr == 5'(i))) begin
          ctrl_reg[i] <= host_req.data;                           // [RULE8]
        end
      end
    end else begin : g_ro
      assign ctrl_reg[i] = REG_RESET;
    end
  end

  always_comb begin
    status_byte                = '0;
    status_byte[ST_PWR_STATE]  = power_state;
    status_byte[ST_SEC_FAULT]  = monitor.sec_fault;
    status_byte[ST_GAUGE_NV]   = monitor.gauge_not_valid;
    status_byte[ST_DC_VALID]   = monitor.dc_valid;
    status_byte[ST_BACKUP_LOW] = monitor.backup_low;
    status_byte[ST_END_DIS]    = monitor.end_discharge;
    status_byte[ST_CHARGING]   = monitor.charging;
    status_byte[ST_INT_FLAG]   = int_flag;
  end

  logic [7:0] reg_rd_value;

  always_comb begin
    case (cmd_addr)
      IDX_GAUGE_HI:   reg_rd_value = monitor.gauge[15:8];
      IDX_GAUGE_LO:   reg_rd_value = monitor.gauge[7:0];
      IDX_LASTCAP_HI: reg_rd_value = monitor.last_capacity[15:8];
      IDX_LASTCAP_LO: reg_rd_value = monitor.last_capacity[7:0];
      IDX_STATUS:     reg_rd_value = status_byte;
      default:        reg_rd_value = reg_addr_ok ? ctrl_reg[cmd_addr] : 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // read data latch
  // ----------------------------------------------------------------
  logic       ram_fetch;
  logic [7:0] reg_fetch_data;
  logic       reg_fetch;

  // the read target is fetched when the command arrives
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ram_fetch      <= 1'b0;
      reg_fetch      <= 1'b0;
      reg_fetch_data <= 8'h00;
    end else begin
      ram_fetch      <= ram_rd_en;
      reg_fetch      <= cmd_wr && (cmd_code == CMD_REG_RD) && reg_addr_ok; // [RULE12]
      reg_fetch_data <= reg_rd_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
    end else if (ram_fetch) begin
      host_rdata <= ram_rd_data;
    end else if (reg_fetch) begin
      host_rdata <= reg_fetch_data;
    end
  end

  assign host_rdata_oe = data_rd && ((access == ST_RAM_RD) || (access == ST_REG_RD));

  // ----------------------------------------------------------------
  // power switch and interrupt
  // ----------------------------------------------------------------
  logic button_prev;
  logic press;
  logic sys_off_cmd;
  logic status_read;
  logic int_active;

  assign press       = button_prev && !power_button_input;
  assign sys_off_cmd = cmd_wr && (cmd_code == CMD_SYS_OFF);
  assign status_read = data_rd && (access == ST_REG_RD) && (access_addr == IDX_STATUS);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      button_prev <= 1'b1;
    end else begin
      button_prev <= power_button_input;
    end
  end

  // a press while off wins over a system off in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      power_state <= 1'b0;
    end else if (press && !power_state) begin
      power_state <= 1'b1;                                        // [RULE2]
    end else if (sys_off_cmd) begin
      power_state <= 1'b0;                                        // [RULE3]
    end
  end

  // flag clears on a status read, a new press wins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      int_flag <= 1'b0;
    end else if (press) begin
      int_flag <= 1'b1;                                           // [RULE4]
    end else if (status_read) begin
      int_flag <= 1'b0;
    end
  end

  bmh_pulse_timer #(
    .LENGTH (INT_PULSE_LEN)
  ) u_int_pulse (                                                 // [RULE4]
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .trigger (press),
    .active  (int_active)
  );

  assign interrupt_out           = 1'b0;
  assign interrupt_oe            = int_active;                    // [RULE4]
  assign supply_switch_drive_out = 1'b0;
  assign supply_switch_drive_oe  = power_state;                   // [RULE2] [RULE3]

  // ----------------------------------------------------------------
  // annunciator outputs
  // ----------------------------------------------------------------
  logic [7:0] ann_mask;
  logic [7:0] ann_ctrl;

  assign ann_mask = ctrl_reg[IDX_ANN_MASK];
  assign ann_ctrl = ctrl_reg[IDX_ANN_CTRL];

  for (genvar k = 0; k < ANN_OUTS; k++) begin : g_ann
    if (k < ANN_STATUS_OUTS) begin : g_both
      assign annunciator_power_outputs_oe[k] = ann_mask[k] ? status_byte[k]  // [RULE16]
                                                           : ann_ctrl[k];    // [RULE1]
    end else begin : g_host
      assign annunciator_power_outputs_oe[k] = !ann_mask[k] && ann_ctrl[k];  // [RULE1]
    end
  end

  assign annunciator_power_outputs_out = '0;

  // ----------------------------------------------------------------
  // charge control
  // ----------------------------------------------------------------
  logic start_pending;
  logic start_cmd;
  logic abort_cmd;

  assign start_cmd = cmd_wr && (cmd_code == CMD_CHG_START);
  assign abort_cmd = cmd_wr && (cmd_code == CMD_CHG_ABORT);

  // start waits here until DC input is valid
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      start_pending <= 1'b0;
    end else if (abort_cmd || (press && !power_state)) begin
      start_pending <= 1'b0;
    end else if (start_cmd) begin
      start_pending <= 1'b1;                                      // [RULE13]
    end else if (monitor.dc_valid) begin
      start_pending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      charge_ctl <= '0;
    end else begin
      charge_ctl.start              <= start_pending && monitor.dc_valid && !abort_cmd; // [RULE13]
      charge_ctl.abort              <= abort_cmd;                 // [RULE15]
      charge_ctl.stop               <= press && !power_state;     // [RULE2]
      charge_ctl.auto_start_allowed <= !power_state;              // [RULE14]
    end
  end

endmodule // bmh_command_port

/* File: verification/bmh_command_port_properties.sv */
// concurrent checks on the host command port
`timescale 1ns/100ps
module bmh_command_port_properties
  import bmh_pkg::*;
#(
  parameter int INT_PULSE_LEN = INT_PULSE_CYC
) (
  input wire logic                ref_clk,
  input wire logic                rst_n,
  input wire bmh_host_req_s       host_req,
  input wire logic [7:0]          host_rdata,
  input wire logic                host_rdata_oe,
  input wire logic                power_button_input,
  input wire logic                supply_switch_drive_out,
  input wire logic                supply_switch_drive_oe,
  input wire logic                interrupt_out,
  input wire logic                interrupt_oe,
  input wire logic [ANN_OUTS-1:0] annunciator_power_outputs_out,
  input wire logic [ANN_OUTS-1:0] annunciator_power_outputs_oe,
  input wire bmh_monitor_s        monitor,
  input wire bmh_charge_ctl_s     charge_ctl
);
  logic       btn_prev;
  int         int_cnt;
  wire        press    = btn_prev && !power_button_input;
  wire        cmd_wr   = host_req.wr && !host_req.register_select;
  wire [2:0]  cmd_code = host_req.data[7:5];

  always_ff @(posedge ref_clk) begin
    if (!rst_n) btn_prev <= 1'b1;
    else btn_prev <= power_button_input;
  end

  // length of the current interrupt pulse, restarted by each press
  always_ff @(posedge ref_clk) begin
    if (!rst_n || press) int_cnt <= 0;
    else if (interrupt_oe) int_cnt <= int_cnt + 1;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_cmd(logic [2:0] code);
    cmd_wr && cmd_code == code;
  endsequence
  sequence s_start_then_dc;
    s_cmd(CMD_CHG_START) ##1 (monitor.dc_valid && !cmd_wr && !press);
  endsequence

  press_interrupt_a: assert property (press |=> interrupt_oe)
    else $error("interrupt pulse missing after press");
  pulse_length_a: assert property ($fell(interrupt_oe) |-> int_cnt == INT_PULSE_LEN)
    else $error("interrupt pulse has wrong length");
  press_drive_a: assert property (press && !supply_switch_drive_oe |=> supply_switch_drive_oe && charge_ctl.stop)
    else $error("press while off did not drive supply and stop charge");
  drive_hold_a: assert property (supply_switch_drive_oe && !(cmd_wr && cmd_code == CMD_SYS_OFF) |=> supply_switch_drive_oe)
    else $error("supply drive dropped without system off");
  off_release_a: assert property (cmd_wr && cmd_code == CMD_SYS_OFF && !press |=> !supply_switch_drive_oe)
    else $error("system off did not release supply drive");
  abort_pulse_a: assert property (s_cmd(CMD_CHG_ABORT) |=> charge_ctl.abort)
    else $error("abort command gave no abort pulse");
  start_pulse_a: assert property (s_start_then_dc |=> charge_ctl.start)
    else $error("start command with dc valid gave no start pulse");
  auto_start_a: assert property (supply_switch_drive_oe |=> !charge_ctl.auto_start_allowed)
    else $error("automatic start allowed while power state on");
  nop_quiet_a: assert property (s_cmd(CMD_NOP) ##0 !press |=> $stable(supply_switch_drive_oe) && !charge_ctl.abort)
    else $error("no operation command changed state");
  rdata_enable_a: assert property (host_rdata_oe |-> host_req.rd && host_req.register_select)
    else $error("read data driven outside a data read");
endmodule // bmh_command_port_properties

bind bmh_command_port bmh_command_port_properties #(.INT_PULSE_LEN(INT_PULSE_LEN)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .host_req(host_req), .host_rdata(host_rdata),
  .host_rdata_oe(host_rdata_oe), .power_button_input(power_button_input),
  .supply_switch_drive_out(supply_switch_drive_out), .supply_switch_drive_oe(supply_switch_drive_oe),
  .interrupt_out(interrupt_out), .interrupt_oe(interrupt_oe),
  .annunciator_power_outputs_out(annunciator_power_outputs_out),
  .annunciator_power_outputs_oe(annunciator_power_outputs_oe), .monitor(monitor), .charge_ctl(charge_ctl));

/* File: verification/bmh_host_model.sv */
// host processor model driving the register-select bus
`timescale 1ns/100ps
module bmh_host_model
  import bmh_pkg::*;
(
  input  wire logic       ref_clk,
  output bmh_host_req_s   host_req,
  input  wire logic [7:0] host_rdata,
  input  wire logic       host_rdata_oe
);
  initial host_req = '{1'b0, 1'b0, 1'b1, 8'h00};

  // one strobe cycle; released data lines show the inverse value
  task automatic xfer(input logic w, input logic r, input logic rs, input logic [7:0] d,
                      output logic oe, output logic [7:0] q);
    @(posedge ref_clk);
    #1 host_req <= '{w, r, rs, d};
    #20 oe = host_rdata_oe;
    q = host_rdata;
    @(posedge ref_clk);
    #1 host_req <= '{1'b0, 1'b0, rs, ~d};
  endtask

  task automatic command(input logic [2:0] code, input logic [4:0] a);
    logic       o;
    logic [7:0] q;
    xfer(1'b1, 1'b0, 1'b0, {code, a}, o, q);
  endtask

  task automatic write_byte(input logic [2:0] code, input logic [4:0] a, input logic [7:0] d);
    logic       o;
    logic [7:0] q;
    command(code, a);
    xfer(1'b1, 1'b0, 1'b1, d, o, q);
  endtask

  // read data byte kept at least two edges behind its command
  task automatic read_byte(input logic [2:0] code, input logic [4:0] a, output logic o, output logic [7:0] q);
    command(code, a);
    @(posedge ref_clk);
    xfer(1'b0, 1'b1, 1'b1, 8'h00, o, q);
  endtask
endmodule // bmh_host_model

/* File: verification/battery_manager_host_command_port_tb_top.sv */
// self-checking testbench of the host command port
`timescale 1ns/100ps
module battery_manager_host_command_port_tb_top
  import bmh_pkg::*;
();
  localparam int PULSE = 4;
  logic                ref_clk = 1'b0;
  logic                rst_n = 1'b0;
  logic                power_button_input = 1'b1;
  bmh_monitor_s        monitor;
  bmh_host_req_s       host_req;
  logic [7:0]          host_rdata;
  logic                host_rdata_oe;
  logic                drive_oe;
  logic                int_oe;
  logic [ANN_OUTS-1:0] ann_oe;
  bmh_charge_ctl_s     charge_ctl;
  int                  bad_count = 0;
  int                  num_checks = 0;
  int                  n_int, n_stop, n_start, n_abort;
  logic [7:0]          shadow [REG_BYTES];
  logic [7:0]          ram_exp [RAM_BYTES];
  logic                ps_exp = 1'b0;
  logic                intf_exp = 1'b0;
  logic                o;
  logic [7:0]          q;

  always #25 ref_clk = ~ref_clk;

  bmh_command_port #(.INT_PULSE_LEN(PULSE)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .host_req(host_req), .host_rdata(host_rdata),
    .host_rdata_oe(host_rdata_oe), .power_button_input(power_button_input),
    .supply_switch_drive_out(), .supply_switch_drive_oe(drive_oe), .interrupt_out(), .interrupt_oe(int_oe),
    .annunciator_power_outputs_out(), .annunciator_power_outputs_oe(ann_oe),
    .monitor(monitor), .charge_ctl(charge_ctl));
  bmh_host_model u_host (.ref_clk(ref_clk), .host_req(host_req), .host_rdata(host_rdata),
                         .host_rdata_oe(host_rdata_oe));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic stop_test;
    if (bad_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] exp_reg(input int i);
    case (i)
      5: return monitor.gauge[15:8];
      6: return monitor.gauge[7:0];
      9: return monitor.last_capacity[15:8];
      10: return monitor.last_capacity[7:0];
      15: return {ps_exp, monitor.sec_fault, monitor.gauge_not_valid, monitor.dc_valid,
                  monitor.backup_low, monitor.end_discharge, monitor.charging, intf_exp};
      default: return shadow[i];
    endcase
  endfunction

  function automatic logic [7:0] exp_ann(input logic [7:0] m, input logic [7:0] c, input logic [7:0] s);
    exp_ann = 8'h00;
    for (int k = 0; k < ANN_OUTS; k++) begin
      exp_ann[k] = (k < ANN_STATUS_OUTS && m[k]) ? s[k] : (!m[k] && c[k]);
    end
  endfunction

  // counts pulses and pulse cycles seen on the control outputs
  task automatic watch(input int cycles);
    n_int = 0;
    n_stop = 0;
    n_start = 0;
    n_abort = 0;
    repeat (cycles) begin
      @(posedge ref_clk);
      #2;
      if (int_oe === 1'b1) n_int++;
      if (charge_ctl.stop === 1'b1) n_stop++;
      if (charge_ctl.start === 1'b1) n_start++;
      if (charge_ctl.abort === 1'b1) n_abort++;
    end
  endtask

  task automatic chk_reg(input int i);
    u_host.read_byte(CMD_REG_RD, 5'(i), o, q);
    chk({7'h00, o}, 8'h01, "read enable");
    chk(q, exp_reg(i), "register read");
    if (i == 15) intf_exp = 1'b0;
  endtask

  task automatic cmd_watch(input logic [2:0] code);
    fork
      u_host.command(code, 5'h00);
      watch(8);
    join
  endtask

  task automatic press(input logic was_off);
    fork
      watch(3 * PULSE);
      begin
        @(posedge ref_clk);
        #1 power_button_input = 1'b0;
        @(posedge ref_clk);
        #1 power_button_input = 1'b1;
      end
    join
    chk(8'(n_int), 8'(PULSE), "interrupt length");
    chk(8'(n_stop), {7'h00, was_off}, "stop pulse");
    chk({7'h00, drive_oe}, 8'h01, "supply drive");
    ps_exp = 1'b1;
    intf_exp = 1'b1;
  endtask

  task automatic set_dc(input logic v);
    fork
      watch(6);
      begin
        @(posedge ref_clk);
        #1 monitor.dc_valid = v;
      end
    join
  endtask

  initial begin
    #4000000;
    bad_count++;
    stop_test();
  end

  initial begin
    void'($urandom(25));
    monitor = bmh_monitor_s'(38'({$urandom(), $urandom()}));
    monitor.dc_valid = 1'b0;
    foreach (shadow[i]) shadow[i] = REG_RESET;
    shadow[1] = SETUP1_RESET;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < REG_BYTES; i++) chk_reg(i);
    for (int i = 0; i < REG_BYTES; i++) begin
      q = 8'($urandom());
      u_host.write_byte(CMD_REG_WR, 5'(i), q);
      if (REG_WRITABLE[i]) shadow[i] = q;
    end
    for (int i = 0; i < REG_BYTES; i++) chk_reg(i);
    u_host.write_byte(CMD_REG_WR, 5'h11, 8'h5A);
    u_host.xfer(1'b1, 1'b0, 1'b1, 8'hC3, o, q);
    u_host.read_byte(CMD_REG_RD, 5'h1F, o, q);
    chk({7'h00, o}, 8'h00, "disallowed read enable");
    chk_reg(1);
    chk_reg(16);
    for (int a = 0; a < RAM_BYTES; a++) begin
      ram_exp[a] = 8'($urandom());
      u_host.write_byte(CMD_RAM_WR, 5'(a), ram_exp[a]);
    end
    for (int a = RAM_BYTES - 1; a >= 0; a--) begin
      u_host.read_byte(CMD_RAM_RD, 5'(a), o, q);
      chk(q, ram_exp[a], "storage read");
    end
    chk_reg(1);
    for (int k = 0; k < 6; k++) begin
      shadow[13] = (k == 0) ? 8'h00 : (k == 1) ? 8'h7F : 8'($urandom());
      shadow[14] = (k == 1) ? 8'h00 : 8'($urandom());
      u_host.write_byte(CMD_REG_WR, IDX_ANN_MASK, shadow[13]);
      u_host.write_byte(CMD_REG_WR, IDX_ANN_CTRL, shadow[14]);
      chk({1'b0, ann_oe}, exp_ann(shadow[13], shadow[14], exp_reg(15)), "annunciator");
    end
    press(1'b1);
    chk_reg(15);
    chk_reg(15);
    press(1'b0);
    cmd_watch(CMD_CHG_START);
    chk(8'(n_start), 8'h00, "start without dc");
    set_dc(1'b1);
    chk(8'(n_start), 8'h01, "start when dc valid");
    cmd_watch(CMD_CHG_START);
    chk(8'(n_start), 8'h01, "start with dc valid");
    set_dc(1'b0);
    set_dc(1'b1);
    chk(8'(n_start), 8'h00, "start without command");
    cmd_watch(CMD_CHG_ABORT);
    chk(8'(n_abort), 8'h01, "abort pulse");
    cmd_watch(CMD_NOP);
    chk(8'(n_abort + n_start + n_stop), 8'h00, "no operation pulses");
    chk({7'h00, drive_oe}, 8'h01, "no operation drive");
    cmd_watch(CMD_SYS_OFF);
    chk({7'h00, drive_oe}, 8'h00, "system off drive");
    ps_exp = 1'b0;
    chk_reg(15);
    stop_test();
  end
endmodule // battery_manager_host_command_port_tb_top
